// [common/fault_pkg.sv]
// fault_pkg: shared constants and carrier types for the fault supervisor
// assumes a single 100 MHz clock domain
package fault_pkg;

    localparam int CLK_PERIOD_NS = 10;
    // glitch filter time on monitor inputs, in ns
    localparam int DEGLITCH_NS = 1000;
    localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // default trimmed cycle counts for bootstrap undervoltage
    localparam int BOOT_FCS_CYC_DEF = 8;
    localparam int BOOT_REFRESH_CYC_DEF = 4;
    // default hiccup off time, in ns
    localparam int HICCUP_OFF_NS = 2000;
    localparam int HICCUP_OFF_CYC = HICCUP_OFF_NS / CLK_PERIOD_NS;

    // status byte field positions
    localparam int ST_BUSY = 7;
    localparam int ST_OFF = 6;
    localparam int ST_VOUT = 5;
    localparam int ST_IOUT = 4;
    localparam int ST_INPUT = 3;
    localparam int ST_TEMP = 2;
    localparam int ST_LOGIC = 1;
    localparam int ST_OTHER = 0;
    localparam logic [7:0] STATUS_RST = 8'h00;
    // latched fault bits
    localparam logic [7:0] LATCH_MASK = 8'h3e;

    // raw monitor flags, all active high
    typedef struct packed {
        logic thermalShutdown;
        logic peakCurrentTrip;
        logic feedbackOvervoltage;
        logic backupOvervoltage;
        logic inputUndervoltage;
        logic inputGuard;
        logic bootstrapUndervoltage;
        logic currentLimitRaw;
    } monitor_s;

    localparam int MON_W = $bits(monitor_s);

    // converter operating context
    typedef struct packed {
        logic softStart;
        logic microSleep;
        logic internalFeedback;
        logic powerSave;
        logic forcedContinuousSwitching;
        logic modePinLow;
        logic converterOff;
        logic outputLow;
        logic busy;
    } context_s;

    // actions toward the converter core
    typedef struct packed {
        logic stopConverter;
        logic powerStageHiZ;
        logic blockForcedContinuous;
        logic refreshSwitching;
        logic holdConverterOff;
        logic inputRegulationRun;
    } action_s;

endpackage

// [rtl/deglitch.sv]
// deglitch: per-bit synchroniser plus agreement filter for monitor inputs
// assumes inputs are asynchronous to clk
`timescale 1ns/1ps
module deglitch import fault_pkg::*; #(
    parameter int WIDTH = MON_W,
    parameter int HOLD = DEGLITCH_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    // raw and filtered
    input wire logic [WIDTH-1:0] rawIn,
    output logic [WIDTH-1:0] cleanOut
);
    localparam int CW = $clog2(HOLD + 1);

    if (HOLD < 1) begin : g_hold_chk
        $error("deglitch HOLD must be at least 1");
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1_r, s2_r, s3_r;
            logic [CW-1:0] cnt_r;
            logic out_r;
            always_ff @(posedge clk) begin
                if (reset) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                end else if (clkEn) begin
                    s1_r <= rawIn[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                end
            end
            // level must stay stable HOLD cycles before it is taken
            always_ff @(posedge clk) begin
                if (reset) begin
                    cnt_r <= '0;
                    out_r <= 1'b0;
                end else if (clkEn) begin
                    if (s2_r != s3_r || s3_r == out_r) begin
                        cnt_r <= '0;
                    end else if (cnt_r == CW'(HOLD - 1)) begin
                        cnt_r <= '0;
                        out_r <= s3_r;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
            end
            assign cleanOut[i] = out_r;
        end
    endgenerate
endmodule // deglitch

// [rtl/fault_counter.sv]
// fault_counter: counts qualified events up to a limit and flags expiry
// assumes event is a one-cycle pulse on clk
`timescale 1ns/1ps
module fault_counter #(
    parameter int LIMIT = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    // control
    input wire logic arm,
    input wire logic tick,
    output logic expired
);
    localparam int CW = $clog2(LIMIT + 1);
    logic [CW-1:0] cnt_r;

    if (LIMIT < 1) begin : g_limit_chk
        $error("fault_counter LIMIT must be at least 1");
    end

    // disarm clears too, but only while the clock enable runs
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_r <= '0;
        end else if (clkEn) begin
            if (!arm) begin
                cnt_r <= '0;
            end else if (tick && cnt_r != CW'(LIMIT)) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    assign expired = arm && (cnt_r == CW'(LIMIT));
endmodule // fault_counter

// [rtl/fault_status_protection.sv]
// fault_status_protection: gathers monitor flags, reacts, reports status byte and pin
// assumes a register interface delivers write/read strobes; monitors are async
//
// Behaviour
// - checksum mismatch sets the logic fault flag.
// - current limit active low when limiter off, high at threshold.
// - power-delivery status follows filtered current limit signal, unlatched.
// - mode 0: pin active for any fault in status byte.
// - indicator mode: pin releases on restart or when fault clears.
// - all status inputs are de-glitched, bounding pin reaction delay; here only the monitor flags are, not checksum or context.
// - mode 1: pin toggles on each change of unlatched or delivery inputs.
// - writing or reading the fault clear byte clears latched faults.
// - writing 1 to a set status bit clears that bit.
// - thermal shutdown stops converter; resumes after hysteresis release.
// - hiccup enabled and peak current trip: stop then restart.
// - feedback overvoltage flagged but regulation continues.
// - feedback overvoltage masked during micro-sleep.
// - feedback overvoltage masked in soft-start and internal feedback.
// - backup overvoltage puts power stage high impedance until it falls.
// - backup overvoltage threshold programmable; circuit may be off in power save.
// - input guard above threshold blocks forced continuous switching.
// - input regulation runs with both enables; pauses while mode pin low. Here it also runs only in forced continuous switching.
// - forced switching bootstrap undervoltage stops after trimmed cycle count.
// - power-save bootstrap undervoltage refreshes, deactivates after trimmed count.
// - checksum mismatch after boot holds converter off.
// - fault flags stay latched until host clears or power cycles.
`timescale 1ns/1ps
module fault_status_protection import fault_pkg::*; #(
    parameter int BOOT_FCS_CYC = BOOT_FCS_CYC_DEF,
    parameter int BOOT_REFRESH_CYC = BOOT_REFRESH_CYC_DEF,
    parameter int HICCUP_CYC = HICCUP_OFF_CYC,
    parameter int THR_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    // monitors and context
    input wire monitor_s monitorRaw,
    input wire context_s ctx,
    input wire logic switchCycle,
    // configuration bits
    input wire logic interruptModeSelect,
    input wire logic currentLimiterEnable,
    input wire logic hiccupEnable,
    input wire logic backupOvervoltageEnable,
    input wire logic inputGuardEnable,
    input wire logic inputRegulationEnable,
    input wire logic [THR_W-1:0] backupOvervoltageThreshold,
    input wire logic [THR_W-1:0] inputGuardThreshold,
    // memory boot check
    input wire logic checksumValid,
    input wire logic checksumMismatch,
    // host access strobes
    input wire logic clearFaultsWrite,
    input wire logic clearFaultsRead,
    input wire logic statusWrite,
    input wire logic [7:0] statusWriteData,
    // status outputs
    output logic [7:0] statusByte,
    output logic [7:0] powerDeliveryStatusByte,
    output logic currentLimitActive,
    output logic [THR_W-1:0] backupOvervoltageThresholdOut,
    output logic [THR_W-1:0] inputGuardThresholdOut,
    // actions
    output action_s action,
    // fault pin, open drain
    input wire logic faultInterruptPinIn,
    output logic faultInterruptPinOut,
    output logic faultInterruptPinOe
);

    if (THR_W < 1) begin : g_thr_chk
        $error("THR_W must be at least 1");
    end
    if (HICCUP_CYC < 1) begin : g_hic_chk
        $error("HICCUP_CYC must be at least 1");
    end

    typedef enum logic [1:0] {RUN, HICCUP_OFF, RESTART} hiccup_e;

    monitor_s mon;
    logic [7:0] latched_r, latched_nxt;
    logic [7:0] faultSet;
    logic fbOvQualified, backupOvQualified, limitNow, logicFault_r;
    logic bootFcsExpired, bootRefreshExpired, bootFault_r;
    logic [7:0] instant, instantPrev_r;
    logic [7:0] pdPrev_r;
    logic pinToggle_r, pinPrevMode_r;
    logic converterOffPrev_r;
    hiccup_e hiccup_r;
    logic [$clog2(HICCUP_CYC+1)-1:0] hiccupCnt_r;

    deglitch #(.WIDTH(MON_W), .HOLD(DEGLITCH_CYC)) u_deglitch (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .rawIn(monitorRaw),
        .cleanOut(mon)
    );

    // qualified fault sources
    assign fbOvQualified = mon.feedbackOvervoltage && !ctx.microSleep
        && !ctx.softStart && !ctx.internalFeedback;
    assign backupOvQualified = mon.backupOvervoltage
        && backupOvervoltageEnable;
    assign limitNow = currentLimiterEnable && mon.currentLimitRaw;
    assign currentLimitActive = limitNow;
    assign backupOvervoltageThresholdOut = backupOvervoltageThreshold;
    assign inputGuardThresholdOut = inputGuardThreshold;

    // logic fault: checksum compared after memory boot
    always_ff @(posedge clk) begin
        if (reset) begin
            logicFault_r <= 1'b0;
        end else if (clkEn && checksumValid) begin
            logicFault_r <= checksumMismatch;
        end
    end

    always_comb begin
        faultSet = 8'h00;
        faultSet[ST_VOUT] = fbOvQualified || backupOvQualified;
        faultSet[ST_IOUT] = mon.peakCurrentTrip;
        faultSet[ST_INPUT] = mon.inputUndervoltage;
        faultSet[ST_TEMP] = mon.thermalShutdown;
        faultSet[ST_LOGIC] = logicFault_r || bootFault_r;
    end

    // latched faults: clears first, then sets win
    always_comb begin
        latched_nxt = latched_r;
        if (clearFaultsWrite || clearFaultsRead) begin
            latched_nxt = 8'h00;
        end else if (statusWrite) begin
            // zero bits keep their value
            latched_nxt = latched_r & ~statusWriteData;
        end
        latched_nxt = (latched_nxt | faultSet) & LATCH_MASK;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            latched_r <= STATUS_RST;
        end else if (clkEn) begin
            latched_r <= latched_nxt;
        end
    end

    always_comb begin
        statusByte = latched_r;
        statusByte[ST_BUSY] = ctx.busy;
        statusByte[ST_OFF] = ctx.converterOff || ctx.outputLow;
        statusByte[ST_OTHER] = 1'b0;
    end

    // unlatched delivery status, no holding
    assign powerDeliveryStatusByte = {7'h00, limitNow};

    // instantaneous status inputs for interrupt mode
    assign instant = faultSet;

    // hiccup sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            hiccup_r <= RUN;
            hiccupCnt_r <= '0;
        end else if (clkEn) begin
            unique case (hiccup_r)
                RUN: begin
                    if (hiccupEnable && mon.peakCurrentTrip) begin
                        hiccup_r <= HICCUP_OFF;
                        hiccupCnt_r <= '0;
                    end
                end
                HICCUP_OFF: begin
                    if (hiccupCnt_r == ($clog2(HICCUP_CYC+1))'(HICCUP_CYC - 1)) begin
                        hiccup_r <= RESTART;
                    end else begin
                        hiccupCnt_r <= hiccupCnt_r + 1'b1;
                    end
                end
                RESTART: begin
                    hiccup_r <= RUN;
                end
                default: hiccup_r <= RUN;
            endcase
        end
    end

    // bootstrap undervoltage in each switching mode
    fault_counter #(.LIMIT(BOOT_FCS_CYC)) u_boot_fcs (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .arm(mon.bootstrapUndervoltage && ctx.forcedContinuousSwitching),
        .tick(switchCycle),
        .expired(bootFcsExpired)
    );

    fault_counter #(.LIMIT(BOOT_REFRESH_CYC)) u_boot_ref (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .arm(mon.bootstrapUndervoltage && ctx.powerSave),
        .tick(switchCycle),
        .expired(bootRefreshExpired)
    );

    // boot fault holds converter stopped until it is switched off with bootstrap undervoltage gone
    always_ff @(posedge clk) begin
        if (reset) begin
            bootFault_r <= 1'b0;
        end else if (clkEn) begin
            if (bootFcsExpired || bootRefreshExpired) begin
                bootFault_r <= 1'b1;
            end else if (ctx.converterOff && !mon.bootstrapUndervoltage) begin
                bootFault_r <= 1'b0;
            end
        end
    end

    always_comb begin
        action = '0;
        action.stopConverter = mon.thermalShutdown
            || hiccup_r == HICCUP_OFF
            || bootFault_r;
        action.powerStageHiZ = backupOvQualified;
        action.blockForcedContinuous = inputGuardEnable && mon.inputGuard;
        action.refreshSwitching = mon.bootstrapUndervoltage && ctx.powerSave
            && !bootRefreshExpired;
        action.holdConverterOff = logicFault_r;
        action.inputRegulationRun = inputGuardEnable && inputRegulationEnable
            && !ctx.modePinLow && ctx.forcedContinuousSwitching;
    end

    // interrupt mode: toggle on each change; mode change resets the toggle
    always_ff @(posedge clk) begin
        if (reset) begin
            instantPrev_r <= 8'h00;
            pdPrev_r <= 8'h00;
            pinToggle_r <= 1'b0;
            pinPrevMode_r <= 1'b0;
            converterOffPrev_r <= 1'b0;
        end else if (clkEn) begin
            instantPrev_r <= instant;
            pdPrev_r <= powerDeliveryStatusByte;
            pinPrevMode_r <= interruptModeSelect;
            converterOffPrev_r <= ctx.converterOff;
            if (pinPrevMode_r != interruptModeSelect) begin
                pinToggle_r <= 1'b0;
            end else if (instant != instantPrev_r
                || powerDeliveryStatusByte != pdPrev_r) begin
                pinToggle_r <= ~pinToggle_r;
            end
        end
    end

    // indicator mode follows live faults, so restart or clearing releases the pin
    logic indicatorActive;
    assign indicatorActive = |(faultSet & LATCH_MASK)
        && !(converterOffPrev_r && !ctx.converterOff);

    always_comb begin
        faultInterruptPinOut = 1'b0;
        if (interruptModeSelect) begin
            faultInterruptPinOe = pinToggle_r;
        end else begin
            faultInterruptPinOe = indicatorActive;
        end
    end

endmodule // fault_status_protection

// [sim/fault_status_protection_tb.sv]
// fault_status_protection_tb: directed scenarios for the fault supervisor
// assumes fsp_props and host_model compiled first
`timescale 1ns/1ps
module fault_status_protection_tb import fault_pkg::*;;
    localparam int SETTLE = DEGLITCH_CYC + 10;
    localparam int HIC = 20;
    logic clk = 1'b0;
    logic reset = 1'b1;
    monitor_s mon = '0;
    context_s cx = '0;
    logic irqMode = 1'b0, limEn = 1'b0, hicEn = 1'b0, bovEn = 1'b0, igEn = 1'b0;
    logic irEn = 1'b0, chkValid = 1'b0, chkMis = 1'b0, clrW = 1'b0, clrR = 1'b0, stW = 1'b0;
    logic [7:0] stData = 8'h00;
    logic sw = 1'b0;
    logic [7:0] statusByte, pdByte, bovOut;
    logic limAct, pinOe, pinLevel;
    action_s act;
    int edgeCnt, error_cnt = 0, n_checks = 0;

    fault_status_protection #(.HICCUP_CYC(HIC)) u_dut (
        .clk(clk), .reset(reset), .clkEn(1'b1),
        .monitorRaw(mon), .ctx(cx), .switchCycle(sw),
        .interruptModeSelect(irqMode), .currentLimiterEnable(limEn),
        .hiccupEnable(hicEn), .backupOvervoltageEnable(bovEn),
        .inputGuardEnable(igEn), .inputRegulationEnable(irEn),
        .backupOvervoltageThreshold(8'h5a), .inputGuardThreshold(8'ha5),
        .checksumValid(chkValid), .checksumMismatch(chkMis),
        .clearFaultsWrite(clrW), .clearFaultsRead(clrR),
        .statusWrite(stW), .statusWriteData(stData),
        .statusByte(statusByte), .powerDeliveryStatusByte(pdByte),
        .currentLimitActive(limAct), .backupOvervoltageThresholdOut(bovOut),
        .inputGuardThresholdOut(), .action(act),
        .faultInterruptPinIn(pinLevel), .faultInterruptPinOut(), .faultInterruptPinOe(pinOe)
    );
    host_model u_host (.clk(clk), .pinOe(pinOe), .pinLevel(pinLevel), .edgeCnt(edgeCnt));

    initial begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic set_mon(input monitor_s m);
        @(posedge clk);
        mon <= m;
    endtask
    task automatic set_cx(input context_s c);
        @(posedge clk);
        cx <= c;
    endtask
    // k = {clear write, clear read, status write}; busy is never raised
    task automatic host_op(input logic [2:0] k, input logic [7:0] d);
        @(posedge clk);
        {clrW, clrR, stW} <= k;
        stData <= d;
        @(posedge clk);
        {clrW, clrR, stW} <= 3'b000;
        cyc(1);
    endtask
    task automatic t_reset();
        chk("status", statusByte & LATCH_MASK, 8'h00);
        chk("pin", {7'h00, pinOe}, 8'h00);
        chk("thr", bovOut, 8'h5a);
    endtask
    task automatic t_limit();
        set_mon(8'h01);
        cyc(SETTLE);
        chk("lim off", {7'h00, limAct}, 8'h00);
        @(posedge clk);
        limEn <= 1'b1;
        cyc(1);
        chk("lim on", {7'h00, limAct}, 8'h01);
        chk("pd", pdByte, 8'h01);
        set_mon(8'h00);
        cyc(SETTLE);
        chk("pd low", pdByte, 8'h00);
    endtask
    task automatic t_thermal();
        set_mon(8'h80);
        cyc(SETTLE);
        chk("tsd bit", statusByte & LATCH_MASK, 8'h04);
        chk("tsd stop", {7'h00, act.stopConverter}, 8'h01);
        chk("pin act", {7'h00, pinLevel}, 8'h00);
        set_mon(8'h00);
        cyc(SETTLE);
        chk("resume", {7'h00, act.stopConverter}, 8'h00);
        chk("pin rel", {7'h00, pinLevel}, 8'h01);
        host_op(3'b001, 8'h00);
        chk("wr zero", statusByte & LATCH_MASK, 8'h04);
        host_op(3'b001, 8'hfb);
        chk("wr other", statusByte & LATCH_MASK, 8'h04);
        host_op(3'b001, 8'h04);
        chk("wr one", statusByte & LATCH_MASK, 8'h00);
    endtask
    task automatic t_glitch();
        set_mon(8'h80);
        repeat (DEGLITCH_CYC / 2) @(posedge clk);
        set_mon(8'h00);
        cyc(SETTLE);
        chk("glitch", statusByte & LATCH_MASK, 8'h00);
    endtask
    task automatic t_clear();
        for (int k = 0; k < 2; k++) begin
            set_mon(8'h60);
            cyc(SETTLE);
            chk("ov oc", statusByte & LATCH_MASK, 8'h30);
            chk("regulate", {7'h00, act.stopConverter}, 8'h00);
            set_mon(8'h00);
            cyc(SETTLE);
            host_op(k == 0 ? 3'b100 : 3'b010, 8'h00);
            chk("cleared", statusByte & LATCH_MASK, 8'h00);
        end
    endtask
    task automatic t_mask();
        for (int i = 0; i < 3; i++) begin
            set_cx(9'h100 >> i);
            set_mon(8'h20);
            cyc(SETTLE);
            chk("masked", statusByte & LATCH_MASK, 8'h00);
            set_mon(8'h00);
            cyc(SETTLE);
            set_cx(9'h000);
        end
    endtask
    task automatic t_hiccup();
        int n;
        @(posedge clk);
        hicEn <= 1'b1;
        set_mon(8'h40);
        cyc(SETTLE);
        chk("hic stop", {7'h00, act.stopConverter}, 8'h01);
        for (n = 0; n < HIC + 5 && act.stopConverter; n++) cyc(1);
        chk("restart", {7'h00, act.stopConverter}, 8'h00);
        set_mon(8'h00);
        hicEn <= 1'b0;
        cyc(SETTLE + HIC);
        host_op(3'b100, 8'h00);
    endtask
    task automatic t_backup();
        @(posedge clk);
        bovEn <= 1'b1;
        set_mon(8'h10);
        cyc(SETTLE);
        chk("hiz", {7'h00, act.powerStageHiZ}, 8'h01);
        set_mon(8'h00);
        cyc(SETTLE);
        chk("hiz off", {7'h00, act.powerStageHiZ}, 8'h00);
        host_op(3'b100, 8'h00);
    endtask
    task automatic t_guard();
        @(posedge clk);
        igEn <= 1'b1;
        irEn <= 1'b1;
        set_cx(9'h010);
        set_mon(8'h04);
        cyc(SETTLE);
        chk("block", {7'h00, act.blockForcedContinuous}, 8'h01);
        chk("ivr run", {7'h00, act.inputRegulationRun}, 8'h01);
        set_cx(9'h018);
        cyc(1);
        chk("ivr pause", {7'h00, act.inputRegulationRun}, 8'h00);
        set_mon(8'h00);
        cyc(SETTLE);
        chk("unblock", {7'h00, act.blockForcedContinuous}, 8'h00);
        set_cx(9'h000);
    endtask
    task automatic pulse_sw(input int n);
        repeat (n) begin
            @(posedge clk);
            sw <= 1'b1;
            @(posedge clk);
            sw <= 1'b0;
        end
        cyc(2);
    endtask
    // k = 0: power-save refresh count, k = 1: forced switching count
    task automatic t_boot();
        for (int k = 0; k < 2; k++) begin
            set_cx(k == 0 ? 9'h020 : 9'h010);
            set_mon(8'h02);
            cyc(SETTLE);
            chk("refresh", {7'h00, act.refreshSwitching}, 8'(1 - k));
            pulse_sw((k == 0 ? BOOT_REFRESH_CYC_DEF : BOOT_FCS_CYC_DEF) - 1);
            chk("boot early", {7'h00, act.stopConverter}, 8'h00);
            pulse_sw(1);
            chk("boot stop", {7'h00, act.stopConverter}, 8'h01);
            chk("boot flag", statusByte & LATCH_MASK, 8'h02);
            set_mon(8'h00);
            cyc(SETTLE);
            set_cx(9'h004);
            host_op(3'b100, 8'h00);
            chk("boot rel", statusByte & LATCH_MASK, 8'h00);
        end
    endtask
    task automatic t_irq();
        int e;
        set_cx(9'h004);
        @(posedge clk);
        irqMode <= 1'b1;
        cyc(3);
        e = edgeCnt;
        set_mon(8'h01);
        cyc(SETTLE);
        chk("irq set", 8'(edgeCnt - e), 8'h01);
        set_mon(8'h00);
        cyc(SETTLE);
        chk("irq clr", 8'(edgeCnt - e), 8'h02);
        @(posedge clk);
        irqMode <= 1'b0;
        set_cx(9'h000);
    endtask
    task automatic t_crc();
        @(posedge clk);
        chkValid <= 1'b1;
        chkMis <= 1'b1;
        @(posedge clk);
        chkValid <= 1'b0;
        chkMis <= 1'b0;
        cyc(2);
        chk("logic", statusByte & LATCH_MASK, 8'h02);
        chk("hold off", {7'h00, act.holdConverterOff}, 8'h01);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        cyc(1);
        t_reset();
        t_limit();
        t_thermal();
        t_glitch();
        t_clear();
        t_mask();
        t_hiccup();
        t_backup();
        t_guard();
        t_boot();
        t_irq();
        t_crc();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_sim();
    end
endmodule // fault_status_protection_tb
bind fault_status_protection fsp_props #(.THR_W(THR_W)) u_props (.*);

// [sim/fsp_props.sv]
// fsp_props: port-level assertions for the fault supervisor
// assumes binding into fault_status_protection with clkEn held high
`timescale 1ns/1ps
module fsp_props import fault_pkg::*; #(
    parameter int THR_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // stimulus side
    input wire monitor_s monitorRaw,
    input wire context_s ctx,
    input wire logic interruptModeSelect,
    input wire logic currentLimiterEnable,
    input wire logic inputGuardEnable,
    input wire logic inputRegulationEnable,
    input wire logic [THR_W-1:0] backupOvervoltageThreshold,
    input wire logic checksumValid,
    input wire logic checksumMismatch,
    input wire logic clearFaultsWrite,
    input wire logic clearFaultsRead,
    input wire logic statusWrite,
    input wire logic [7:0] statusWriteData,
    // design outputs
    input wire logic [7:0] statusByte,
    input wire logic [7:0] powerDeliveryStatusByte,
    input wire logic currentLimitActive,
    input wire logic [THR_W-1:0] backupOvervoltageThresholdOut,
    input wire action_s action,
    input wire logic faultInterruptPinOe
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // set wins over clear until the filters have drained
    int quiet_r;
    logic calm;
    always_ff @(posedge clk) begin
        if (reset || monitorRaw != '0 || (checksumValid && checksumMismatch)) begin
            quiet_r <= 0;
        end else if (quiet_r < 1000) begin
            quiet_r <= quiet_r + 1;
        end
    end
    assign calm = quiet_r > DEGLITCH_CYC + 5;
    sequence clr_s;
        (clearFaultsWrite || clearFaultsRead) && calm;
    endsequence
    sequence wr_s;
        statusWrite && !clearFaultsWrite && !clearFaultsRead;
    endsequence
    a_clear_all: assert property (clr_s |=> (statusByte & LATCH_MASK) == 8'h00)
        else $error("latched faults survive a clear");
    a_one_clears: assert property (wr_s and calm |=>
        (statusByte & $past(statusWriteData) & LATCH_MASK) == 8'h00)
        else $error("written one did not clear");
    a_zero_keeps: assert property (wr_s |=> ($past(statusByte) & ~$past(statusWriteData)
        & LATCH_MASK & ~statusByte) == 8'h00)
        else $error("written zero disturbed a fault");
    a_limit_off: assert property (!currentLimiterEnable |-> !currentLimitActive)
        else $error("limit active while limiter off");
    a_pd_follow: assert property (powerDeliveryStatusByte == {7'h00, currentLimitActive})
        else $error("delivery byte not following limit");
    a_fault_pin: assert property (!interruptModeSelect
        && (statusByte & ~$past(statusByte) & 8'h3c) != 8'h00 |-> $past(faultInterruptPinOe))
        else $error("pin idle on new fault");
    a_tsd_stop: assert property ($rose(statusByte[ST_TEMP]) |-> $past(action.stopConverter))
        else $error("thermal fault without stop");
    a_irq_toggle: assert property (interruptModeSelect && $stable(interruptModeSelect)
        && $changed(powerDeliveryStatusByte) |=> $changed(faultInterruptPinOe))
        else $error("interrupt pin did not toggle");
    a_ivr_gate: assert property (action.inputRegulationRun |->
        inputGuardEnable && inputRegulationEnable && !ctx.modePinLow)
        else $error("input regulation ran ungated");
    a_thr_pass: assert property (backupOvervoltageThresholdOut == backupOvervoltageThreshold)
        else $error("threshold not passed through");
    a_crc_hold: assert property (checksumValid && checksumMismatch |->
        ##[1:2] statusByte[ST_LOGIC] && action.holdConverterOff)
        else $error("checksum fault not held");
endmodule // fsp_props

// [sim/host_model.sv]
// host_model: host end of the open-drain fault pin, with pull-up
// assumes the device only ever pulls the pin low
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic clk,
    // pin
    input wire logic pinOe,
    output logic pinLevel,
    output int edgeCnt
);
    // pull-up: a released pin reads high, never the last driven level
    assign pinLevel = pinOe ? 1'b0 : 1'b1;
    logic prevR = 1'b1;
    initial edgeCnt = 0;
    always @(posedge clk) begin
        if (pinLevel !== prevR) begin
            edgeCnt <= edgeCnt + 1;
        end
        prevR <= pinLevel;
    end
endmodule // host_model
